// ### inc/mchk_frame_regs.vh
/*
 * Register offsets, frame constants, reset values and codes for the machine
 * check frame builder. Assumes a 32-bit classic Wishbone slave with word
 * aligned byte addresses.
 */
`ifndef MCHK_FRAME_REGS_VH
`define MCHK_FRAME_REGS_VH

// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_VEC_BASE 8'h08
`define OFS_FRAME_SP 8'h0c
`define OFS_ERR_ADDR 8'h10
`define OFS_FRAME0 8'h20

// Internal processor register number of the vector table base.
`define VEC_BASE_IPR 8'h11
// Vector table offset shared by all machine checks.
`define VEC_MCHK_OFS 32'h00000004

// Machine check codes.
`define MC_FP_PROTO 8'h01
`define MC_FP_RSVD 8'h02
`define MC_FP_STAT_A 8'h03
`define MC_FP_STAT_B 8'h04
`define MC_MM_P0_MISS 8'h05
`define MC_MM_P1_MISS 8'h06
`define MC_MM_P0_MOD 8'h07
`define MC_MM_P1_MOD 8'h08
`define MC_INT_LEVEL 8'h09
`define MC_UCODE 8'h0a
`define MC_RD_OPER 8'h80
`define MC_RD_SYS 8'h81
`define MC_WR_OPER 8'h82
`define MC_WR_SYS 8'h83

// Frame layout and constant fields.
`define FRAME_WORDS 7
`define FRAME_BYTE_COUNT 32'h00000010
`define SWI_FILL 4'hf
`define FLAG_FILL 2'h3
`define CC_FILL 3'h7
`define ADDR_BUMP 32'h00000004

// Reset values.
`define VEC_BASE_RST 32'h00000000
`define FRAME_SP_RST 32'h00000000

`endif

// ### verilog/mchk_frame_builder.v
/*
 * Machine check classifier and stack frame builder with a Wishbone register
 * file. Assumes the core presents error events and its state as levels on
 * core_clk, and that software reads the built frame from the registers.
 */
// Chosen here: register access over Wishbone and the register addresses.
`include "mchk_frame_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module mchk_frame_builder #(
    parameter ADDR_W = 8
) (
    input wire core_clk,
    input wire rstn,
    // Classic Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // Error event sources, one-cycle pulses from core logic.
    input wire bus_parity_err,
    input wire cache_parity_err,
    input wire bus_timeout_err,
    input wire err_no_ready,
    input wire fp_protocol_err,
    input wire fp_reserved_instr,
    input wire [1:0] fp_bad_status,
    input wire mm_pte_program_region,
    input wire mm_pte_control_region,
    input wire mm_modify_update,
    input wire unused_level_request,
    input wire string_move_bad_state,
    input wire access_is_write,
    input wire access_is_system,
    // Core state captured into the frame.
    input wire [31:0] access_vaddr,
    input wire [31:0] access_paddr,
    input wire [7:0] opcode,
    input wire [3:0] highest_swi,
    input wire [7:0] cache_control_bits,
    input wire [7:0] memory_error_flags,
    input wire [7:0] internal_shift_counter,
    input wire [5:0] state_flags,
    input wire cannot_restart,
    input wire [3:0] alu_ccodes,
    input wire [31:0] instr_start_pc,
    input wire [31:0] processor_status_longword,
    input wire [31:0] stack_pointer,
    // Machine check results toward the core.
    output reg mchk_taken,
    output reg [31:0] mchk_vector_addr,
    output reg [31:0] frame_sp,
    output reg unrecoverable
);

    localparam ST_IDLE = 2'b01;
    localparam ST_HELD = 2'b10;

    reg [1:0] state_ff;
    reg [31:0] frame_ff [0:`FRAME_WORDS-1];
    reg [31:0] vec_base_ff;
    reg [31:0] err_addr_ff;
    reg [7:0] code_ff;
    reg overrun_ff;
    reg [7:0] nxt_code;
    reg [31:0] nxt_addr;
    reg nxt_unrec;
    reg mchk_event;
    integer i;

    // Classification: hardware detected errors are read or write errors;
    // fixed priority puts coprocessor first because those arrive mid-instruction.
    always @* begin
        nxt_code = 8'h00;
        nxt_unrec = 1'b0;
        mchk_event = 1'b1;
        if (fp_protocol_err) begin
            nxt_code = `MC_FP_PROTO;
        end else if (fp_reserved_instr) begin
            nxt_code = `MC_FP_RSVD;
        end else if (fp_bad_status[1]) begin
            nxt_code = fp_bad_status[0] ? `MC_FP_STAT_B : `MC_FP_STAT_A;
        end else if (mm_pte_program_region) begin
            nxt_code = mm_modify_update ? `MC_MM_P0_MOD : `MC_MM_P0_MISS;
            nxt_unrec = 1'b1;
        end else if (mm_pte_control_region) begin
            nxt_code = mm_modify_update ? `MC_MM_P1_MOD : `MC_MM_P1_MISS;
            nxt_unrec = 1'b1;
        end else if (unused_level_request) begin
            nxt_code = `MC_INT_LEVEL;
            nxt_unrec = 1'b1;
        end else if (string_move_bad_state) begin
            nxt_code = `MC_UCODE;
            nxt_unrec = 1'b1;
        end else if (bus_parity_err | cache_parity_err | bus_timeout_err | err_no_ready) begin
            if (access_is_write) begin
                nxt_code = access_is_system ? `MC_WR_SYS : `MC_WR_OPER;
                nxt_unrec = 1'b1;
            end else begin
                nxt_code = access_is_system ? `MC_RD_SYS : `MC_RD_OPER;
                nxt_unrec = cannot_restart & ~processor_status_longword[27];
            end
        end else begin
            mchk_event = 1'b0;
        end
    end

    // Address parameter, plus 4: physical whenever access_is_system is set, whatever the code, virtual otherwise.
    always @* begin
        nxt_addr = (access_is_system ? access_paddr : access_vaddr) + `ADDR_BUMP;
    end

    // Frame capture. The frame is held until software releases it, so a
    // second check meanwhile only sets the sticky overrun flag, never overwrites.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            for (i = 0; i < `FRAME_WORDS; i = i + 1) begin
                frame_ff[i] <= 32'h00000000;
            end
            err_addr_ff <= 32'h00000000;
            code_ff <= 8'h00;
            overrun_ff <= 1'b0;
            mchk_taken <= 1'b0;
            mchk_vector_addr <= 32'h00000000;
            frame_sp <= `FRAME_SP_RST;
            unrecoverable <= 1'b0;
        end else begin
            mchk_taken <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (mchk_event) begin
                        mchk_taken <= 1'b1;
                        mchk_vector_addr <= vec_base_ff + `VEC_MCHK_OFS;
                        frame_sp <= stack_pointer - 32'h0000001c;
                        code_ff <= nxt_code;
                        err_addr_ff <= nxt_addr;
                        unrecoverable <= nxt_unrec;
                        frame_ff[0] <= `FRAME_BYTE_COUNT;
                        frame_ff[1] <= {24'h000000, nxt_code};
                        frame_ff[2] <= nxt_addr;
                        frame_ff[3] <= {opcode, `SWI_FILL, highest_swi,
                                        cache_control_bits, memory_error_flags};
                        frame_ff[4] <= {internal_shift_counter,
                                        `FLAG_FILL, state_flags,
                                        cannot_restart,
                                        `CC_FILL, alu_ccodes,
                                        access_vaddr[7:0] - instr_start_pc[7:0]};
                        frame_ff[5] <= instr_start_pc;
                        frame_ff[6] <= processor_status_longword;
                        state_ff <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (mchk_event) begin
                        overrun_ff <= 1'b1;
                    end
                    if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                            && wb_adr_i == `OFS_CTRL && wb_sel_i[0] && wb_dat_i[0]) begin
                        state_ff <= ST_IDLE;
                        if (!mchk_event) begin
                            overrun_ff <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Wishbone slave: one wait-free ack per request, err on unmapped
    // addresses. The vector table base is writable; low bits stay zero
    // since the table is page aligned.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            vec_base_ff <= `VEC_BASE_RST;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) begin
                wb_dat_o <= 32'h00000000;
                if (wb_adr_i == `OFS_CTRL) begin
                    wb_ack_o <= 1'b1;
                end else if (wb_adr_i == `OFS_STATUS) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {14'h0000, overrun_ff, unrecoverable,
                                 8'h00, code_ff[7:0]} | {31'h00000000, 1'b0}
                                 | {state_ff[1], 31'h00000000};
                end else if (wb_adr_i == `OFS_VEC_BASE) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= vec_base_ff;
                    if (wb_we_i) begin
                        if (wb_sel_i[1]) vec_base_ff[15:9] <= wb_dat_i[15:9];
                        if (wb_sel_i[2]) vec_base_ff[23:16] <= wb_dat_i[23:16];
                        if (wb_sel_i[3]) vec_base_ff[29:24] <= wb_dat_i[29:24];
                    end
                end else if (wb_adr_i == `OFS_FRAME_SP) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= frame_sp;
                end else if (wb_adr_i == `OFS_ERR_ADDR) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= err_addr_ff;
                end else if (wb_adr_i >= `OFS_FRAME0 && wb_adr_i < `OFS_FRAME0 + 8'h1c
                             && wb_adr_i[1:0] == 2'b00) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= frame_ff[wb_adr_i[4:2]];
                end else begin
                    wb_err_o <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/mchk_frame_builder_asserts.sv
/*
 * Port checker for the machine check frame builder.
 * Assumes one core_clk domain with rstn active low; attached by the bind at the foot.
 */
`timescale 1ns/100ps
`default_nettype none
module mchk_frame_asserts (
    input wire core_clk,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [7:0] wb_adr_i,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire mchk_taken,
    input wire [31:0] mchk_vector_addr,
    input wire [31:0] frame_sp,
    input wire [31:0] stack_pointer
);
    // All checks share the core clock and rest while reset is held.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // A bus answer comes one cycle after the request is taken and lasts one cycle.
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_answer; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o || wb_err_o; endproperty
    property p_cause; wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_one_kind; !(wb_ack_o && wb_err_o); endproperty
    // An error answer is only allowed for an address outside the map.
    property p_err_map;
        wb_err_o |-> !($past(wb_adr_i) inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20,
            8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38});
    endproperty
    // A held frame refuses new checks, so the taken flag never lasts two cycles.
    property p_taken_pulse; mchk_taken |=> !mchk_taken; endproperty
    // The base has no bits below 9, so the shared slot always shows as 0x004.
    property p_vector; mchk_taken |-> mchk_vector_addr[8:0] == 9'h004; endproperty
    property p_frame_sp; mchk_taken |-> frame_sp == $past(stack_pointer) - 32'h1c; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_answer: assert property (p_answer) else $error("request not answered in one cycle");
    a_cause: assert property (p_cause) else $error("answer without request");
    a_one_kind: assert property (p_one_kind) else $error("ack and err together");
    a_err_map: assert property (p_err_map) else $error("err on mapped address");
    a_taken_pulse: assert property (p_taken_pulse) else $error("taken held");
    a_vector: assert property (p_vector) else $error("bad vector offset");
    a_frame_sp: assert property (p_frame_sp) else $error("bad frame pointer");
    c_taken: cover property (mchk_taken);
    c_err: cover property (wb_err_o);
    c_back: cover property (wb_ack_o ##2 wb_ack_o);
endmodule
bind mchk_frame_builder mchk_frame_asserts u_chk (.*);
`default_nettype wire

// ### verif/machine_check_frame_builder_tb.sv
/*
 * Self-checking bench for the machine check frame builder.
 * Assumes the register header is on the include path and the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mchk_frame_regs.vh"
module machine_check_frame_builder_tb;
    logic core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
    logic bus_parity_err, cache_parity_err, bus_timeout_err, err_no_ready, fp_protocol_err;
    logic fp_reserved_instr, mm_pte_program_region, mm_pte_control_region, mm_modify_update;
    logic unused_level_request, string_move_bad_state, access_is_write, access_is_system;
    logic cannot_restart, mchk_taken, unrecoverable;
    logic [1:0] fp_bad_status;
    logic [3:0] wb_sel_i, highest_swi, alu_ccodes;
    logic [5:0] state_flags;
    logic [7:0] wb_adr_i, opcode, cache_control_bits, memory_error_flags, internal_shift_counter;
    logic [7:0] code;
    logic [31:0] wb_dat_i, wb_dat_o, access_vaddr, access_paddr, instr_start_pc, frame_sp;
    logic [31:0] processor_status_longword, stack_pointer, mchk_vector_addr, q, w[7];
    int n_mismatch = 0, checks = 0, cycles = 0, n;
    // One event pattern per code, bit 0 being the rightmost name in drive_ev.
    logic [14:0] pat[14] = '{15'h0001, 15'h0002, 15'h0008, 15'h000c, 15'h0010, 15'h0020,
        15'h0050, 15'h0060, 15'h0080, 15'h0100, 15'h0200, 15'h4400, 15'h2800, 15'h7000};

    mchk_frame_builder dut (.*);

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Classic single cycle; the wait is bounded so a dead slave cannot hang the run.
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, wr, a, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        e = wb_err_o;
        chk("bus answer", 1'b1, wb_ack_o | wb_err_o);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, exp, q);
    endtask
    task automatic drive_ev(input logic [14:0] p);
        {access_is_system, access_is_write, err_no_ready, bus_timeout_err, cache_parity_err,
            bus_parity_err, string_move_bad_state, unused_level_request, mm_modify_update,
            mm_pte_control_region, mm_pte_program_region, fp_bad_status, fp_reserved_instr,
            fp_protocol_err} <= p;
    endtask
    // Core state moves with each test so that a stuck frame field shows up.
    task automatic set_state(input logic [3:0] i);
        access_vaddr <= 32'h40000034 + {i, 4'h0};
        access_paddr <= 32'h00123450 + i;
        opcode <= 8'h28 + i;
        highest_swi <= i;
        cache_control_bits <= 8'ha5 ^ i;
        memory_error_flags <= 8'h40 + i;
        internal_shift_counter <= 8'hc3 - i;
        state_flags <= 6'h2a ^ i;
        cannot_restart <= i[0];
        alu_ccodes <= i ^ 4'h9;
        instr_start_pc <= 32'h40000010 + i;
        processor_status_longword <= {4'h0, i[2], 27'h41f0000};
        stack_pointer <= 32'h00008000 - {i, 6'h00};
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // The run needs well under a thousand cycles; four thousand means a hang.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        rstn <= 1'b0;
        wb_sel_i <= 4'hf;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= '0;
        drive_ev(15'h0000);
        set_state(4'h0);
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`OFS_VEC_BASE, `VEC_BASE_RST, "base reset");
        rd(`OFS_FRAME_SP, `FRAME_SP_RST, "frame sp reset");
        bus(`OFS_VEC_BASE, 1'b1, 32'hffffffff);
        rd(`OFS_VEC_BASE, 32'h3ffffe00, "base bits");
        bus(`OFS_VEC_BASE, 1'b1, 32'h00004600);
        bus(8'h14, 1'b0, 32'h0);
        chk("unmapped err", 1'b1, e);
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            code = (i < 10) ? 8'(i + 1) : 8'(i + 8'h76);
            set_state(4'(i));
            drive_ev(pat[i]);
            @(posedge core_clk);
            drive_ev(15'h0000);
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (mchk_taken !== 1'b1 && n < 8);
            chk("taken", 1'b1, mchk_taken);
            chk("vector", 32'h00004604, mchk_vector_addr);
            chk("frame sp", stack_pointer - 32'h1c, frame_sp);
            // Every class from page table errors upward is fatal; reads only with cannot_restart set and PSL bit 27 clear.
            chk("unrec", i >= 4 && !((i == 10 || i == 11)
                && !(cannot_restart && !processor_status_longword[27])),
                unrecoverable);
            w = '{`FRAME_BYTE_COUNT, {24'h0, code},
                (pat[i][14] ? access_paddr : access_vaddr) + `ADDR_BUMP,
                {opcode, `SWI_FILL, highest_swi, cache_control_bits, memory_error_flags},
                {internal_shift_counter, `FLAG_FILL, state_flags, cannot_restart, `CC_FILL,
                    alu_ccodes, access_vaddr[7:0] - instr_start_pc[7:0]},
                instr_start_pc, processor_status_longword};
            bus(`OFS_FRAME0, 1'b1, 32'hffffffff);
            for (int k = 0; k < 3; k++)
                rd(8'h20 + 8'(4 * k), w[k], "frame");
            for (int k = 3; k < 7; k++)
                rd(8'h20 + 8'(4 * k), w[k], "frame");
            bus(`OFS_STATUS, 1'b0, 32'h0);
            chk("status", {1'b1, code}, {q[31], q[7:0]});
            if (i == 13) begin
                drive_ev(15'h0200);
                @(posedge core_clk);
                drive_ev(15'h0000);
                @(posedge core_clk);
                chk("refused", 1'b0, mchk_taken);
                bus(`OFS_STATUS, 1'b0, 32'h0);
                chk("overrun", 1'b1, q[17]);
                rd(8'h24, 32'h00000083, "kept code");
            end
            bus(`OFS_CTRL, 1'b1, 32'h00000001);
            $display("test code %h done", code);
        end
        bus(`OFS_STATUS, 1'b0, 32'h0);
        chk("released", 1'b0, q[31]);
        give_verdict();
    end
endmodule
`default_nettype wire
